// File: rsf_slave.sv
// Slave end: receives, checks and answers telegrams on the RS-485 line.
`timescale 1ns/1ns
`include "rsf_cfg.svh"
module rsf_slave #(
  parameter int unsigned RESP_MAX_CYC = `RSF_RESP_MAX_US * (`RSF_CLK_HZ / 1000000)
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Configuration
  input wire logic [15:0] baud_div_in,
  input wire logic [6:0] station_in,
  input wire logic [1:0] profile_in,
  // Received telegram
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic [7:0] rx_addr_out,
  output logic rx_bcast_out,
  output logic tel_ok_out,
  output logic tel_bad_out,
  // Response data
  input wire logic [7:0] resp_len_in,
  input wire logic [7:0] resp_data_in,
  input wire logic resp_valid_in,
  output logic resp_ready_out,
  output logic resp_busy_out,
  // Line
  rsf_link_if.slave link
);

  // ****************************************************************
  // Character receiver
  // ****************************************************************
  logic rx_s1_q;
  logic rx_s2_q;
  logic rx_busy_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [10:0] rx_sh_q;
  logic rx_done_q;
  logic [7:0] rx_byte;
  logic rx_err;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= link.line;
      rx_s2_q <= rx_s1_q;
    end
  end

  // Bit rate follows baud_div_in, clock cycles per bit.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= 16'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 11'h7ff;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx_s2_q) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= baud_div_in >> 1;
          rx_bit_q <= 4'h0;
        end
      end else if (rx_cnt_q == 16'h0) begin
        rx_cnt_q <= baud_div_in - 16'h1;
        rx_sh_q <= {rx_s2_q, rx_sh_q[10:1]};
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == `RSF_CHAR_BITS - 4'h1) begin
          rx_busy_q <= 1'b0;
          rx_done_q <= 1'b1;
        end
      end else begin
        rx_cnt_q <= rx_cnt_q - 16'h1;
      end
    end
  end

  assign rx_byte = rx_sh_q[8:1];
  // Start, stop and even parity are all checked.
  assign rx_err = rx_sh_q[0] | !rx_sh_q[10] | (rsf_pkg::rsf_parity(rx_byte) != rx_sh_q[9]);

  // ****************************************************************
  // Bit-time base and telegram timers
  // ****************************************************************
  rsf_pkg::rsf_slv_st_t st_q;
  logic [15:0] bt_cnt_q;
  logic bit_tick;
  logic [7:0] gap_q;
  logic [15:0] tel_bits_q;
  logic [15:0] lim_q;
  logic [7:0] wait_q;
  logic [31:0] dl_q;
  logic in_rx;
  logic gap_over;
  logic dur_over;

  assign bit_tick = (bt_cnt_q == 16'h0);
  assign in_rx = (st_q == rsf_pkg::SL_LEN) || (st_q == rsf_pkg::SL_BODY);
  assign gap_over = gap_q > `RSF_GAP_BITS;
  assign dur_over = (st_q == rsf_pkg::SL_BODY) && (tel_bits_q > lim_q);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bt_cnt_q <= 16'h0;
    end else begin
      bt_cnt_q <= bit_tick ? baud_div_in - 16'h1 : bt_cnt_q - 16'h1;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gap_q <= 8'h0;
      tel_bits_q <= 16'h0;
      wait_q <= 8'h0;
      dl_q <= 32'h0;
    end else begin
      if (!in_rx || rx_busy_q || rx_done_q) begin
        gap_q <= 8'h0;
      end else if (bit_tick && gap_q != 8'hff) begin
        gap_q <= gap_q + 8'h1;
      end
      // The start character has already taken one character time.
      if (st_q == rsf_pkg::SL_IDLE) begin
        tel_bits_q <= 16'(`RSF_CHAR_BITS);
      end else if (bit_tick && tel_bits_q != 16'hffff) begin
        tel_bits_q <= tel_bits_q + 16'h1;
      end
      if (st_q != rsf_pkg::SL_WAIT) begin
        wait_q <= 8'h0;
        dl_q <= 32'h0;
      end else begin
        dl_q <= dl_q + 32'h1;
        if (bit_tick && wait_q != 8'hff) begin
          wait_q <= wait_q + 8'h1;
        end
      end
    end
  end

  // ****************************************************************
  // Response byte selection
  // ****************************************************************
  logic [7:0] n_q;
  logic [8:0] idx_q;
  logic [8:0] bcc_idx;
  logic [7:0] addr_q;
  logic [7:0] tx_csum_q;
  logic [7:0] tx_byte;
  logic tx_avail;
  logic tx_busy_q;
  logic tx_load;
  logic in_data;

  assign bcc_idx = {1'b0, n_q} + 9'd3;
  assign in_data = (idx_q >= 9'd3) && (idx_q < bcc_idx);

  always_comb begin
    tx_byte = resp_data_in;
    tx_avail = in_data && resp_valid_in;
    if (idx_q == 9'd0) begin
      tx_byte = `RSF_STX;
      tx_avail = 1'b1;
    end else if (idx_q == 9'd1) begin
      tx_byte = n_q + `RSF_LEN_OVH;
      tx_avail = 1'b1;
    end else if (idx_q == 9'd2) begin
      tx_byte = addr_q;
      tx_avail = 1'b1;
    end else if (idx_q == bcc_idx) begin
      tx_byte = tx_csum_q;
      tx_avail = 1'b1;
    end
  end

  assign tx_load = (st_q == rsf_pkg::SL_TX) && !tx_busy_q && tx_avail;
  assign resp_ready_out = (st_q == rsf_pkg::SL_TX) && !tx_busy_q && in_data;
  assign resp_busy_out = (st_q == rsf_pkg::SL_WAIT) || (st_q == rsf_pkg::SL_TX);

  // ****************************************************************
  // Telegram state machine
  // ****************************************************************
  logic [7:0] len_q;
  logic [7:0] rem_q;
  logic [7:0] csum_q;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= rsf_pkg::SL_IDLE;
      len_q <= 8'h0;
      rem_q <= 8'h0;
      csum_q <= 8'h0;
      lim_q <= 16'h0;
      addr_q <= 8'h0;
      n_q <= 8'h0;
      idx_q <= 9'h0;
      tx_csum_q <= 8'h0;
      rx_data_out <= 8'h0;
      rx_valid_out <= 1'b0;
      rx_addr_out <= 8'h0;
      rx_bcast_out <= 1'b0;
      tel_ok_out <= 1'b0;
      tel_bad_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      tel_ok_out <= 1'b0;
      tel_bad_out <= 1'b0;
      case (st_q)
        rsf_pkg::SL_IDLE: begin
          if (rx_done_q && !rx_err && rx_byte == `RSF_STX &&
              profile_in == `RSF_PROFILE_TELEGRAM) begin
            csum_q <= rx_byte;
            st_q <= rsf_pkg::SL_LEN;
          end
        end
        rsf_pkg::SL_LEN: begin
          if (gap_over) begin
            tel_bad_out <= 1'b1;
            st_q <= rsf_pkg::SL_IDLE;
          end else if (rx_done_q) begin
            if (rx_err || rx_byte < `RSF_LEN_OVH) begin
              tel_bad_out <= 1'b1;
              st_q <= rsf_pkg::SL_IDLE;
            end else begin
              len_q <= rx_byte;
              rem_q <= rx_byte;
              csum_q <= csum_q ^ rx_byte;
              lim_q <= rsf_pkg::rsf_dur_lim(rx_byte);
              st_q <= rsf_pkg::SL_BODY;
            end
          end
        end
        rsf_pkg::SL_BODY: begin
          if (gap_over || dur_over || (rx_done_q && rx_err)) begin
            tel_bad_out <= 1'b1;
            st_q <= rsf_pkg::SL_IDLE;
          end else if (rx_done_q) begin
            rem_q <= rem_q - 8'h1;
            if (rem_q == 8'h1) begin
              if (rx_byte == csum_q) begin
                tel_ok_out <= 1'b1;
                n_q <= resp_len_in;
                // Broadcast and foreign telegrams get no answer.
                if (rsf_pkg::rsf_is_mine(addr_q, station_in) &&
                    !rsf_pkg::rsf_is_bcast(addr_q)) begin
                  st_q <= rsf_pkg::SL_WAIT;
                end else begin
                  st_q <= rsf_pkg::SL_IDLE;
                end
              end else begin
                tel_bad_out <= 1'b1;
                st_q <= rsf_pkg::SL_IDLE;
              end
            end else begin
              csum_q <= csum_q ^ rx_byte;
              if (rem_q == len_q) begin
                addr_q <= rx_byte;
                rx_addr_out <= rx_byte;
                rx_bcast_out <= rsf_pkg::rsf_is_bcast(rx_byte);
              end else begin
                rx_data_out <= rx_byte;
                rx_valid_out <= 1'b1;
              end
            end
          end
        end
        rsf_pkg::SL_WAIT: begin
          idx_q <= 9'h0;
          // Baud rates too slow to turn round in time give up the answer.
          if (dl_q >= RESP_MAX_CYC) begin
            st_q <= rsf_pkg::SL_IDLE;
          end else if (wait_q >= `RSF_TURN_BITS + 8'd2) begin
            // Two spare ticks cover the free-running divider and the mid-stop start.
            st_q <= rsf_pkg::SL_TX;
          end
        end
        rsf_pkg::SL_TX: begin
          if (tx_load) begin
            idx_q <= idx_q + 9'h1;
            if (idx_q == 9'd0) begin
              tx_csum_q <= tx_byte;
            end else if (idx_q != bcc_idx) begin
              tx_csum_q <= tx_csum_q ^ tx_byte;
            end
          end else if (!tx_busy_q && idx_q > bcc_idx) begin
            st_q <= rsf_pkg::SL_IDLE;
          end
        end
        default: begin
          st_q <= rsf_pkg::SL_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Character transmitter
  // ****************************************************************
  logic [15:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [10:0] tx_sh_q;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= 16'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 11'h7ff;
    end else if (tx_load) begin
      tx_sh_q <= {1'b1, rsf_pkg::rsf_parity(tx_byte), tx_byte, 1'b0};
      tx_busy_q <= 1'b1;
      tx_cnt_q <= baud_div_in - 16'h1;
      tx_bit_q <= 4'h0;
    end else if (tx_busy_q) begin
      if (tx_cnt_q == 16'h0) begin
        tx_cnt_q <= baud_div_in - 16'h1;
        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        tx_bit_q <= tx_bit_q + 4'h1;
        if (tx_bit_q == `RSF_CHAR_BITS - 4'h1) begin
          tx_busy_q <= 1'b0;
        end
      end else begin
        tx_cnt_q <= tx_cnt_q - 16'h1;
      end
    end
  end

  // The driver is enabled only while answering.
  assign link.s_tx = tx_sh_q[0];
  assign link.s_oe_n = (st_q != rsf_pkg::SL_TX);

endmodule

// File: rsf_cfg.svh
// Constants of the RS-485 slave telegram framer and its master end.
`ifndef RSF_CFG_SVH
`define RSF_CFG_SVH

// ****************************************************************
// Framing
// ****************************************************************
`define RSF_STX 8'h02
`define RSF_CHAR_BITS 4'd11
`define RSF_LEN_OVH 8'd2
`define RSF_FRAME_OVH 8'd2
`define RSF_TXT_FIXED 8'd10
`define RSF_DUR_X2 16'd3
`define RSF_PROFILE_TELEGRAM 2'h1

// ****************************************************************
// Timing
// ****************************************************************
`define RSF_GAP_BITS 8'd22
`define RSF_TURN_BITS 8'd22
`define RSF_PAUSE_BITS 8'd22
`define RSF_CLK_HZ 100000000
`define RSF_RESP_MAX_US 20000
`define RSF_RSP_TMO_US 50000

`endif

// File: rsf_pkg.sv
// Types and shared helpers of the RS-485 telegram framer.
`include "rsf_cfg.svh"
package rsf_pkg;

  typedef enum logic [4:0] {
    SL_IDLE = 5'h01,
    SL_LEN = 5'h02,
    SL_BODY = 5'h04,
    SL_WAIT = 5'h08,
    SL_TX = 5'h10
  } rsf_slv_st_t;

  typedef enum logic [3:0] {
    MS_IDLE = 4'h1,
    MS_TX = 4'h2,
    MS_RSP = 4'h4,
    MS_PAUSE = 4'h8
  } rsf_mst_st_t;

  // Even parity over data plus parity bit.
  function automatic logic rsf_parity(input logic [7:0] d);
    return ^d;
  endfunction

  function automatic logic rsf_is_bcast(input logic [7:0] a);
    return a[7] ? (a[6:0] == 7'h00) : a[5];
  endfunction

  function automatic logic rsf_is_mine(input logic [7:0] a, input logic [6:0] stn);
    if (a[7]) begin
      return (a[6:0] == stn) && (stn != 7'h00);
    end
    return !a[5] && (a[4:0] == stn[4:0]) && (stn[6:5] == 2'b00) && (stn != 7'h00);
  endfunction

  // Longest telegram in bit times: 1.5 times the nominal duration.
  function automatic logic [15:0] rsf_dur_lim(input logic [7:0] telegram_length_byte);
    logic [15:0] nom;
    nom = (16'(telegram_length_byte) + 16'(`RSF_FRAME_OVH)) * 16'(`RSF_CHAR_BITS);
    return 16'((nom * `RSF_DUR_X2) >> 1);
  endfunction

endpackage

// File: rsf_link_if.sv
// Shared RS-485 line between the bus master and the slave framer.
`timescale 1ns/1ns
interface rsf_link_if;
  logic m_tx;
  logic m_oe_n;
  logic s_tx;
  logic s_oe_n;
  logic line;

  // The line idles high when nobody drives it.
  assign line = !m_oe_n ? m_tx : (!s_oe_n ? s_tx : 1'b1);

  modport master (output m_tx, output m_oe_n, input line);
  modport slave (output s_tx, output s_oe_n, input line);
endinterface

// File: rsf_master.sv
// Master end: sends telegrams on the RS-485 line and collects answers.
`timescale 1ns/1ns
`include "rsf_cfg.svh"
module rsf_master #(
  parameter int unsigned RSP_TMO_CYC = `RSF_RSP_TMO_US * (`RSF_CLK_HZ / 1000000)
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  // Configuration
  input wire logic [15:0] baud_div_in,
  // Command
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_addr_in,
  input wire logic [7:0] cmd_len_in,
  output logic cmd_ready_out,
  input wire logic [7:0] data_in,
  input wire logic data_valid_in,
  output logic data_ready_out,
  // Answer
  output logic [7:0] rsp_data_out,
  output logic rsp_valid_out,
  output logic rsp_done_out,
  output logic rsp_ok_out,
  output logic rsp_tmo_out,
  // Line
  rsf_link_if.master link
);

  // ****************************************************************
  // Character receiver and bit-time base
  // ****************************************************************
  logic rx_s1_q;
  logic rx_s2_q;
  logic rx_busy_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [10:0] rx_sh_q;
  logic rx_done_q;
  logic [7:0] rx_byte;
  logic rx_err;
  logic [15:0] bt_cnt_q;
  logic bit_tick;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      bt_cnt_q <= 16'h0;
    end else begin
      rx_s1_q <= link.line;
      rx_s2_q <= rx_s1_q;
      bt_cnt_q <= bit_tick ? baud_div_in - 16'h1 : bt_cnt_q - 16'h1;
    end
  end

  assign bit_tick = (bt_cnt_q == 16'h0);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= 16'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 11'h7ff;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx_s2_q) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q <= baud_div_in >> 1;
          rx_bit_q <= 4'h0;
        end
      end else if (rx_cnt_q == 16'h0) begin
        rx_cnt_q <= baud_div_in - 16'h1;
        rx_sh_q <= {rx_s2_q, rx_sh_q[10:1]};
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == `RSF_CHAR_BITS - 4'h1) begin
          rx_busy_q <= 1'b0;
          rx_done_q <= 1'b1;
        end
      end else begin
        rx_cnt_q <= rx_cnt_q - 16'h1;
      end
    end
  end

  assign rx_byte = rx_sh_q[8:1];
  assign rx_err = rx_sh_q[0] | !rx_sh_q[10] | (rsf_pkg::rsf_parity(rx_byte) != rx_sh_q[9]);

  // ****************************************************************
  // Telegram sequencing
  // ****************************************************************
  rsf_pkg::rsf_mst_st_t st_q;
  logic [7:0] n_q;
  logic [7:0] addr_q;
  logic [8:0] idx_q;
  logic [8:0] bcc_idx;
  logic in_data;
  logic [7:0] tx_csum_q;
  logic [7:0] tx_byte;
  logic tx_avail;
  logic tx_busy_q;
  logic tx_load;
  logic [8:0] rb_q;
  logic [7:0] rlen_q;
  logic [7:0] rcsum_q;
  logic [31:0] tmo_q;
  logic [7:0] gap_q;

  assign bcc_idx = {1'b0, n_q} + 9'd3;
  assign in_data = (idx_q >= 9'd3) && (idx_q < bcc_idx);

  always_comb begin
    tx_byte = data_in;
    tx_avail = in_data && data_valid_in;
    if (idx_q == 9'd0) begin
      tx_byte = `RSF_STX;
      tx_avail = 1'b1;
    end else if (idx_q == 9'd1) begin
      tx_byte = n_q + `RSF_LEN_OVH;
      tx_avail = 1'b1;
    end else if (idx_q == 9'd2) begin
      tx_byte = addr_q;
      tx_avail = 1'b1;
    end else if (idx_q == bcc_idx) begin
      tx_byte = tx_csum_q;
      tx_avail = 1'b1;
    end
  end

  assign tx_load = (st_q == rsf_pkg::MS_TX) && !tx_busy_q && tx_avail;
  assign data_ready_out = (st_q == rsf_pkg::MS_TX) && !tx_busy_q && in_data;
  assign cmd_ready_out = (st_q == rsf_pkg::MS_IDLE);

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tmo_q <= 32'h0;
      gap_q <= 8'h0;
    end else begin
      tmo_q <= (st_q == rsf_pkg::MS_RSP) ? tmo_q + 32'h1 : 32'h0;
      // Counts idle bit times; any line activity restarts it.
      if (rx_busy_q || rx_done_q || st_q == rsf_pkg::MS_TX) begin
        gap_q <= 8'h0;
      end else if (bit_tick && gap_q != 8'hff) begin
        gap_q <= gap_q + 8'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= rsf_pkg::MS_IDLE;
      n_q <= 8'h0;
      addr_q <= 8'h0;
      idx_q <= 9'h0;
      tx_csum_q <= 8'h0;
      rb_q <= 9'h0;
      rlen_q <= 8'h0;
      rcsum_q <= 8'h0;
      rsp_data_out <= 8'h0;
      rsp_valid_out <= 1'b0;
      rsp_done_out <= 1'b0;
      rsp_ok_out <= 1'b0;
      rsp_tmo_out <= 1'b0;
    end else begin
      rsp_valid_out <= 1'b0;
      rsp_done_out <= 1'b0;
      rsp_tmo_out <= 1'b0;
      case (st_q)
        rsf_pkg::MS_IDLE: begin
          idx_q <= 9'h0;
          rb_q <= 9'h0;
          if (cmd_valid_in) begin
            n_q <= cmd_len_in;
            addr_q <= cmd_addr_in;
            st_q <= rsf_pkg::MS_TX;
          end
        end
        rsf_pkg::MS_TX: begin
          if (tx_load) begin
            idx_q <= idx_q + 9'h1;
            if (idx_q == 9'd0) begin
              tx_csum_q <= tx_byte;
            end else if (idx_q != bcc_idx) begin
              tx_csum_q <= tx_csum_q ^ tx_byte;
            end
          end else if (!tx_busy_q && idx_q > bcc_idx) begin
            // No answer comes to a broadcast.
            st_q <= rsf_pkg::rsf_is_bcast(addr_q) ? rsf_pkg::MS_PAUSE : rsf_pkg::MS_RSP;
          end
        end
        rsf_pkg::MS_RSP: begin
          if ((rb_q == 9'h0 && tmo_q >= RSP_TMO_CYC) ||
              (rb_q != 9'h0 && gap_q > `RSF_GAP_BITS)) begin
            rsp_tmo_out <= 1'b1;
            st_q <= rsf_pkg::MS_PAUSE;
          end else if (rx_done_q) begin
            rb_q <= rb_q + 9'h1;
            rcsum_q <= rcsum_q ^ rx_byte;
            if (rb_q == 9'h0) begin
              rcsum_q <= rx_byte;
            end else if (rb_q == 9'h1) begin
              rlen_q <= rx_byte;
            end
            if (rx_err || (rb_q == 9'h0 && rx_byte != `RSF_STX) ||
                (rb_q == 9'h1 && rx_byte < `RSF_LEN_OVH)) begin
              rsp_ok_out <= 1'b0;
              rsp_done_out <= 1'b1;
              st_q <= rsf_pkg::MS_PAUSE;
            end else if (rb_q > 9'h1 && rb_q == {1'b0, rlen_q} + 9'h1) begin
              rsp_ok_out <= (rx_byte == rcsum_q);
              rsp_done_out <= 1'b1;
              st_q <= rsf_pkg::MS_PAUSE;
            end else if (rb_q > 9'h2) begin
              rsp_data_out <= rx_byte;
              rsp_valid_out <= 1'b1;
            end
          end
        end
        rsf_pkg::MS_PAUSE: begin
          if (gap_q >= `RSF_PAUSE_BITS + 8'd2) begin
            // Two spare ticks cover the free-running divider and the mid-stop count.
            st_q <= rsf_pkg::MS_IDLE;
          end
        end
        default: begin
          st_q <= rsf_pkg::MS_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Character transmitter
  // ****************************************************************
  logic [15:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [10:0] tx_sh_q;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= 16'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 11'h7ff;
    end else if (tx_load) begin
      tx_sh_q <= {1'b1, rsf_pkg::rsf_parity(tx_byte), tx_byte, 1'b0};
      tx_busy_q <= 1'b1;
      tx_cnt_q <= baud_div_in - 16'h1;
      tx_bit_q <= 4'h0;
    end else if (tx_busy_q) begin
      if (tx_cnt_q == 16'h0) begin
        tx_cnt_q <= baud_div_in - 16'h1;
        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        tx_bit_q <= tx_bit_q + 4'h1;
        if (tx_bit_q == `RSF_CHAR_BITS - 4'h1) begin
          tx_busy_q <= 1'b0;
        end
      end else begin
        tx_cnt_q <= tx_cnt_q - 16'h1;
      end
    end
  end

  assign link.m_tx = tx_sh_q[0];
  assign link.m_oe_n = (st_q != rsf_pkg::MS_TX);

endmodule

// File: rsf_link_assertions.sv
// Concurrent checks on the shared RS-485 line between master and slave.
`timescale 1ns/1ns
module rsf_link_assertions #(
  parameter int DIV = 16
) (
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic m_tx,
  input wire logic m_oe_n,
  input wire logic s_tx,
  input wire logic s_oe_n,
  input wire logic line
);
  logic [15:0] quiet_q;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  // Saturates, so the first telegram after reset is not held to a pause.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      quiet_q <= 16'hffff;
    end else if (!m_oe_n || !s_oe_n) begin
      quiet_q <= 16'h0000;
    end else if (quiet_q != 16'hffff) begin
      quiet_q <= quiet_q + 16'h0001;
    end
  end
  chk_one_driver: assert property (m_oe_n || s_oe_n)
    else $error("both ends drive");
  chk_mst_start: assert property ($fell(m_oe_n) |=> !m_tx [*8])
    else $error("master start bit");
  chk_slv_start: assert property ($fell(s_oe_n) |=> !s_tx [*8])
    else $error("slave start bit");
  chk_mst_stop: assert property ($rose(m_oe_n) |-> $past(line) && $past(m_tx, 8))
    else $error("master stop bit");
  chk_slv_stop: assert property ($rose(s_oe_n) |-> $past(line) && $past(s_tx, 8))
    else $error("slave stop bit");
  chk_slv_turn_gap: assert property ($fell(s_oe_n) |-> int'(quiet_q) >= 22 * DIV)
    else $error("slave answers early");
  chk_slv_prompt: assert property ($fell(s_oe_n) |-> int'(quiet_q) <= 24 * DIV)
    else $error("slave answers late");
  chk_mst_pause: assert property ($fell(m_oe_n) |-> int'(quiet_q) >= 22 * DIV)
    else $error("master pause short");
endmodule

// File: rs485_slave_telegram_framer_tb.sv
// Bench joining master and slave ends over one line.
`timescale 1ns/1ns
module rs485_slave_telegram_framer_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] prof = 2'h1;
  logic stall = 1'b0;
  logic [15:0] div = 16'h0010;
  logic cv = 1'b0;
  logic dv = 1'b0;
  logic [7:0] ca = 8'h00;
  logic [7:0] cl = 8'h00;
  logic [7:0] dat = 8'h00;
  logic [7:0] rd = 8'ha0;
  logic crdy, drdy, rspv, done, ok, rxv, bc, tok, rrdy, bad, tmo, bsy;
  logic [7:0] rxd, rxa, rspd;
  int fail_count = 0;
  int checks_done = 0;
  int n_rx, n_rsp, n_ok, n_good, n_ans, n_bad, n_tmo, n_bsy, cyc;
  rsf_link_if link ();
  rsf_master #(.RSP_TMO_CYC(2000)) i_rsf_master (.core_clk_in(clk), .arst_n_in(arst_n),
    .baud_div_in(div), .cmd_valid_in(cv), .cmd_addr_in(ca), .cmd_len_in(cl),
    .cmd_ready_out(crdy), .data_in(dat), .data_valid_in(dv), .data_ready_out(drdy),
    .rsp_data_out(rspd), .rsp_valid_out(rspv), .rsp_done_out(done), .rsp_ok_out(ok),
    .rsp_tmo_out(tmo), .link(link));
  rsf_slave #(.RESP_MAX_CYC(1000)) i_rsf_slave (.core_clk_in(clk), .arst_n_in(arst_n),
    .baud_div_in(div), .station_in(7'h05), .profile_in(prof), .rx_data_out(rxd),
    .rx_valid_out(rxv), .rx_addr_out(rxa), .rx_bcast_out(bc), .tel_ok_out(tok),
    .tel_bad_out(bad), .resp_len_in(8'h02), .resp_data_in(rd), .resp_valid_in(1'b1),
    .resp_ready_out(rrdy), .resp_busy_out(bsy), .link(link));
  rsf_link_assertions #(.DIV(16)) i_rsf_link_assertions (.core_clk_in(clk),
    .arst_n_in(arst_n), .m_tx(link.m_tx), .m_oe_n(link.m_oe_n), .s_tx(link.s_tx),
    .s_oe_n(link.s_oe_n), .line(link.line));
  always #5 clk = ~clk;
  always @(negedge link.s_oe_n) n_ans++;
  always @(posedge bsy) n_bsy++;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      test_done();
    end
    if (rxv === 1'b1) begin
      check(rxd, 8'h30 + 8'(n_rx));
      n_rx++;
    end
    if (rspv === 1'b1) begin
      check(rspd, 8'ha0 + 8'(n_rsp));
      n_rsp++;
    end
    if (tok === 1'b1) n_ok++;
    if (bad === 1'b1) n_bad++;
    if (tmo === 1'b1) n_tmo++;
    if (done === 1'b1 && ok === 1'b1) n_good++;
    if (rrdy === 1'b1) rd <= rd + 8'h01;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Sends one telegram, then waits past the answer window before judging.
  task automatic run(input logic [7:0] a, input int n, input logic g, input logic b,
                     input logic ans);
    n_rx = 0;
    n_ok = 0;
    n_good = 0;
    n_ans = 0;
    n_bad = 0;
    n_tmo = 0;
    n_bsy = 0;
    ca = a;
    cl = 8'(n);
    cv = 1'b1;
    @(negedge clk);
    while (crdy !== 1'b1) @(negedge clk);
    @(posedge clk);
    #1 cv = 1'b0;
    // A stall before the first data byte leaves the line idle past the gap limit.
    if (stall) begin
      repeat (1200) @(posedge clk);
      #1;
    end
    for (int i = 0; i < n; i++) begin
      dat = 8'h30 + 8'(i);
      dv = 1'b1;
      @(negedge clk);
      while (drdy !== 1'b1) @(negedge clk);
      @(posedge clk);
      #1;
    end
    dv = 1'b0;
    repeat (3000) @(posedge clk);
    #1;
    check(8'(n_ok), {7'h00, g});
    check(8'(n_rx), g ? 8'(n) : 8'h00);
    check(8'(n_ans), {7'h00, ans});
    check(8'(n_good), {7'h00, ans});
    if (g) check({7'h00, bc}, {7'h00, b});
    if (g) check(rxa, a);
    check(8'(n_bad), {7'h00, stall});
    check(8'(n_tmo), {7'h00, !ans && !b});
    check(8'(n_bsy), {7'h00, ans});
    $display("Test for address %h ended", a);
  endtask
  task automatic t_own(); run(8'h05, 2, 1'b1, 1'b0, 1'b1); endtask
  task automatic t_bcast(); run(8'h3f, 0, 1'b1, 1'b1, 1'b0); endtask
  task automatic t_long(); run(8'h85, 1, 1'b1, 1'b0, 1'b1); endtask
  task automatic t_lbcast(); run(8'h80, 1, 1'b1, 1'b1, 1'b0); endtask
  task automatic t_other(); run(8'h06, 1, 1'b1, 1'b0, 1'b0); endtask
  task automatic t_prof();
    prof = 2'h2;
    run(8'h05, 1, 1'b0, 1'b0, 1'b0);
    prof = 2'h1;
  endtask
  task automatic t_gap();
    stall = 1'b1;
    run(8'h05, 1, 1'b0, 1'b0, 1'b0);
    stall = 1'b0;
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    t_own();
    t_bcast();
    t_long();
    t_lbcast();
    t_other();
    t_prof();
    t_gap();
    test_done();
  end
endmodule
